// ---- rtl/csm_pkg.sv ----
// package: register map, field layouts, reset values and mode coding of the clock source selector
package csm_pkg;

	// register word addresses on the axi4-lite bus
	localparam logic [3:0] CSM_OFS_CTRL1  = 4'h0;
	localparam logic [3:0] CSM_OFS_CTRL2  = 4'h4;
	localparam logic [3:0] CSM_OFS_TRIM   = 4'h8;
	localparam logic [3:0] CSM_OFS_STATUS = 4'hC;

	// axi response codes
	localparam logic [1:0] CSM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CSM_RESP_SLVERR = 2'h2;

	// output source select encodings
	localparam logic [1:0] CSM_SRC_FLL = 2'h0;
	localparam logic [1:0] CSM_SRC_INT = 2'h1;
	localparam logic [1:0] CSM_SRC_EXT = 2'h2;

	// control register one, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] output_source_select;
		logic [2:0] fll_reference_divider;
		logic       fll_reference_select;
		logic       internal_ref_output_enable;
		logic       internal_ref_stop_keep;
	} csm_ctrl1_t;

	// control register two, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] bus_divider;
		logic       ext_range_high;
		logic       ext_high_gain;
		logic       bypass_fll_off;
		logic       ext_ref_osc_select;
		logic       ext_ref_output_enable;
		logic       ext_ref_stop_keep;
	} csm_ctrl2_t;

	// status register, bit 7 down to bit 0
	typedef struct packed {
		logic [2:0] zero_bits;
		logic       reference_source_status;
		logic [1:0] clock_mode_status;
		logic       oscillator_ready_flag;
		logic       fine_period_trim;
	} csm_status_t;

	// reset values: fll engaged on the internal reference, bus divider by two
	localparam csm_ctrl1_t CSM_CTRL1_RST = 8'h04;
	localparam csm_ctrl2_t CSM_CTRL2_RST = 8'h40;
	localparam logic [7:0] CSM_TRIM_RST  = 8'h80;

	// operating modes, gray coded along fei-fee-fbi-bypassed_internal_lowpower_mode-fbe-bypassed_external_lowpower_mode-stop
	typedef enum logic [2:0] {
		CSM_FEI   = 3'h0,
		CSM_FEE   = 3'h1,
		CSM_FBI   = 3'h3,
		CSM_BYPASSED_INTERNAL_LOWPOWER_MODE = 3'h2,
		CSM_FBE   = 3'h6,
		CSM_BYPASSED_EXTERNAL_LOWPOWER_MODE = 3'h7,
		CSM_STOP  = 3'h5
	} csm_mode_t;

	// mode from source select, reference select, low-power bit and stop request
	function automatic csm_mode_t csm_decode(input logic [1:0] src, input logic iref, input logic lp,
		input logic stop);
		csm_mode_t m;
		m = iref ? CSM_FEI : CSM_FEE;
		if (stop) begin
			m = CSM_STOP;
		end else if (src == CSM_SRC_INT) begin
			m = lp ? CSM_BYPASSED_INTERNAL_LOWPOWER_MODE : CSM_FBI;
		end else if (src == CSM_SRC_EXT) begin
			m = lp ? CSM_BYPASSED_EXTERNAL_LOWPOWER_MODE : CSM_FBE;
		end
		return m;
	endfunction

	// modes that run on the internal reference
	function automatic logic csm_is_int(input csm_mode_t m);
		return (m == CSM_FEI) || (m == CSM_FBI) || (m == CSM_BYPASSED_INTERNAL_LOWPOWER_MODE);
	endfunction

	// modes that run on the external reference
	function automatic logic csm_is_ext(input csm_mode_t m);
		return (m == CSM_FEE) || (m == CSM_FBE) || (m == CSM_BYPASSED_EXTERNAL_LOWPOWER_MODE);
	endfunction

endpackage

// ---- rtl/csm_pulse_div.sv ----
// divider of one-cycle enable pulses by two raised to a select value
`timescale 1ns/1ns
`default_nettype none
module csm_pulse_div
	import csm_pkg::*;
#(
	parameter int SEL_W = 3
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             tick_in,
	input  wire logic [SEL_W-1:0] sel,
	output var  logic             tick_out
);
	localparam int CNT_W = (1 << SEL_W) - 1;

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] last_count;

	if (SEL_W < 1 || SEL_W > 4) begin : g_check
		$error("csm_pulse_div: SEL_W must lie in 1..4");
	end

	// terminal count is 2**sel - 1; a select change applies at once, a count already past it wraps on the next input pulse
	assign last_count = CNT_W'((1 << sel) - 1);

	// input pulse counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else if (tick_in) begin
			cnt_q <= (cnt_q >= last_count) ? '0 : cnt_q + 1'b1;
		end
	end

	// registered output pulse, one per 2**sel input pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= tick_in && (cnt_q >= last_count);
		end
	end
endmodule // csm_pulse_div
`default_nettype wire

// ---- rtl/csm_clock_select.sv ----
// clock source selector: fll, internal and external reference, mode control and register file
//
// Notes on behaviour
// - fee: fll on external ref drives output, debug
// - fbi: fll kept locked on internal, output internal; the code takes the fll reference from the reference select bit instead
// - bypassed_internal_lowpower_mode: fll off, output internal, no debug
// - fbe: fll kept on external, output external; the code takes the fll reference from the reference select bit instead
// - bypassed_external_lowpower_mode: fll off, output external, no debug
// - stop: no fll, output, debug; refs per settings
// - source select 00 fll, 01 int, 10 ext
// - reference divider by two to the field
// - reference select one means internal reference
// - output enable gates internal reference clock out
// - stop keep holds internal ref in stop if output-enabled or used by the last mode
// - bus divider 1/2/4/8, bus is half
// - low-power bit turns fll off in bypass modes unless debugging
// - status fields lag writes through two stages; only mode and reference status do here, fine trim does not
// - reset comes up fll engaged internal
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module csm_clock_select
	import csm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// chip-level state and source pulses
	input  wire logic        stop_req,
	input  wire logic        background_debug,
	input  wire logic        int_ref_tick,
	input  wire logic        ext_ref_tick,
	input  wire logic        dco_tick,
	input  wire logic        osc_init_done,
	// controls and clock enables toward the chip
	output var  logic        fll_enable,
	output var  logic        fll_ref_is_int,
	output var  logic        fll_ref_tick,
	output var  logic        int_ref_enable,
	output var  logic        ext_ref_enable,
	output var  logic        ext_range_high,
	output var  logic        ext_high_gain,
	output var  logic        ext_osc_request,
	output var  logic [7:0]  ref_trim,
	output var  logic        fine_trim,
	output var  logic        internal_ref_clock_out,
	output var  logic        ext_ref_clock_out,
	output var  logic        out_clock_tick,
	output var  logic        bus_clock_tick,
	output var  logic        debug_clock_tick
);
	csm_ctrl1_t  ctrl1_q;
	csm_ctrl2_t  ctrl2_q;
	logic [7:0]  trim_q;
	logic        fine_period_trim_q;
	logic        osc_ready_q;
	logic [2:0]  stat1_q;
	logic [2:0]  stat2_q;
	csm_mode_t   mode;
	csm_mode_t   last_run_mode_q;
	logic        fll_on;
	logic        int_on;
	logic        ext_on;
	logic        src_tick;
	logic        ref_sel_tick;
	logic        src_tick_q;
	logic        dco_gated_q;
	logic        ref_gated_q;
	logic        aw_got_q;
	logic        w_got_q;
	logic [3:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic        wstrb0_q;
	logic        wr_fire;
	csm_status_t status;

	// mode decode; reserved source 11 falls to fll output
	assign mode = csm_decode(ctrl1_q.output_source_select, ctrl1_q.fll_reference_select,
		ctrl2_q.bypass_fll_off, stop_req);

	// fll runs unless stopped, or bypassed with low-power set and no debug session
	always_comb begin
		case (mode)
			CSM_FEI, CSM_FEE, CSM_FBI, CSM_FBE: fll_on = 1'b1;
			CSM_BYPASSED_INTERNAL_LOWPOWER_MODE, CSM_BYPASSED_EXTERNAL_LOWPOWER_MODE:               fll_on = background_debug;
			CSM_STOP:                           fll_on = 1'b0;
			default:                            fll_on = 1'b1;
		endcase
	end

	// reference enables; in stop each survives only under its stop-keep bit
	always_comb begin
		if (mode == CSM_STOP) begin
			int_on = ctrl1_q.internal_ref_stop_keep &&
				(ctrl1_q.internal_ref_output_enable || csm_is_int(last_run_mode_q));
			ext_on = ctrl2_q.ext_ref_stop_keep &&
				(ctrl2_q.ext_ref_output_enable || csm_is_ext(last_run_mode_q));
		end else begin
			int_on = ctrl1_q.fll_reference_select || ctrl1_q.internal_ref_output_enable ||
				csm_is_int(mode);
			ext_on = !ctrl1_q.fll_reference_select || ctrl2_q.ext_ref_output_enable ||
				csm_is_ext(mode);
		end
	end

	// output source; stop gives no system clock at all
	always_comb begin
		case (mode)
			CSM_FEI, CSM_FEE:     src_tick = dco_tick;
			CSM_FBI, CSM_BYPASSED_INTERNAL_LOWPOWER_MODE:   src_tick = int_ref_tick;
			CSM_FBE, CSM_BYPASSED_EXTERNAL_LOWPOWER_MODE:   src_tick = ext_ref_tick;
			CSM_STOP:             src_tick = 1'b0;
			default:              src_tick = dco_tick;
		endcase
	end

	// fll reference: internal when the select bit is one
	assign ref_sel_tick = ctrl1_q.fll_reference_select ? int_ref_tick : ext_ref_tick;

	// mode seen before stop, so stop-keep knows which reference was in use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_run_mode_q <= CSM_FEI;
		end else if (mode != CSM_STOP) begin
			last_run_mode_q <= mode;
		end
	end

	// registered gating ahead of the dividers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_tick_q  <= 1'b0;
			dco_gated_q <= 1'b0;
			ref_gated_q <= 1'b0;
		end else begin
			src_tick_q  <= src_tick;
			dco_gated_q <= dco_tick && fll_on; // debug clock only while the fll runs
			ref_gated_q <= ref_sel_tick && fll_on;
		end
	end

	// fll reference divider by 1..128
	csm_pulse_div #(.SEL_W(3)) u_ref_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (ref_gated_q),
		.sel      (ctrl1_q.fll_reference_divider),
		.tick_out (fll_ref_tick)
	);

	// selected source divided by 1/2/4/8
	csm_pulse_div #(.SEL_W(2)) u_out_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (src_tick_q),
		.sel      (ctrl2_q.bus_divider),
		.tick_out (out_clock_tick)
	);

	// bus clock is half the divided output
	csm_pulse_div #(.SEL_W(1)) u_bus_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (out_clock_tick),
		.sel      (1'b1),
		.tick_out (bus_clock_tick)
	);

	// debug clock is the fll output halved
	csm_pulse_div #(.SEL_W(1)) u_dbg_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (dco_gated_q),
		.sel      (1'b1),
		.tick_out (debug_clock_tick)
	);

	// control levels toward the analog parts and reference clock outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fll_enable             <= 1'b1;
			fll_ref_is_int         <= 1'b1;
			int_ref_enable         <= 1'b1;
			ext_ref_enable         <= 1'b0;
			ext_range_high         <= 1'b0;
			ext_high_gain          <= 1'b0;
			ext_osc_request        <= 1'b0;
			ref_trim               <= CSM_TRIM_RST;
			fine_trim              <= 1'b0;
			internal_ref_clock_out <= 1'b0;
			ext_ref_clock_out      <= 1'b0;
		end else begin
			fll_enable             <= fll_on;
			fll_ref_is_int         <= ctrl1_q.fll_reference_select;
			int_ref_enable         <= int_on;
			ext_ref_enable         <= ext_on;
			ext_range_high         <= ctrl2_q.ext_range_high;
			ext_high_gain          <= ctrl2_q.ext_high_gain;
			ext_osc_request        <= ctrl2_q.ext_ref_osc_select;
			ref_trim               <= trim_q;
			fine_trim              <= fine_period_trim_q;
			internal_ref_clock_out <= int_ref_tick && int_on && ctrl1_q.internal_ref_output_enable;
			ext_ref_clock_out      <= ext_ref_tick && ext_on && ctrl2_q.ext_ref_output_enable;
		end
	end

	// status lags writes by two stages, as the mode really switches over
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat1_q <= {1'b1, CSM_SRC_FLL};
			stat2_q <= {1'b1, CSM_SRC_FLL};
		end else begin
			stat1_q <= {ctrl1_q.fll_reference_select,
				(ctrl1_q.output_source_select == 2'h3) ? CSM_SRC_FLL : ctrl1_q.output_source_select};
			stat2_q <= stat1_q;
		end
	end

	// oscillator ready: set once started while in use, cleared by dropping its request or when the external ref is neither enabled nor output-enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_ready_q <= 1'b0;
		end else if (!ctrl2_q.ext_ref_osc_select || !ctrl2_q.ext_ref_output_enable && !ext_on) begin
			osc_ready_q <= 1'b0;
		end else if (osc_init_done) begin
			osc_ready_q <= 1'b1;
		end
	end

	// status view; top three bits are constant zero
	assign status = '{zero_bits: 3'h0, reference_source_status: stat2_q[2],
		clock_mode_status: stat2_q[1:0], oscillator_ready_flag: osc_ready_q, fine_period_trim: fine_period_trim_q};

	// write commit once address and data are both held and no response is pending
	assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

	// write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q      <= 1'b0;
			awaddr_q      <= 4'h0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awready && s_axi_awvalid) begin
			aw_got_q      <= 1'b1;
			awaddr_q      <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else begin
			if (wr_fire) begin
				aw_got_q <= 1'b0;
			end
			s_axi_awready <= !aw_got_q && !s_axi_bvalid;
		end
	end

	// write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_q      <= 1'b0;
			wdata_q      <= 32'h0;
			wstrb0_q     <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wready && s_axi_wvalid) begin
			w_got_q      <= 1'b1;
			wdata_q      <= s_axi_wdata;
			wstrb0_q     <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end else begin
			if (wr_fire) begin
				w_got_q <= 1'b0;
			end
			s_axi_wready <= !w_got_q && !s_axi_bvalid;
		end
	end

	// write response; unmapped addresses answer slverr and store nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CSM_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_q[1:0] == 2'h0) ? CSM_RESP_OKAY : CSM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register stores; only byte lane 0 carries the eight-bit registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_q <= CSM_CTRL1_RST;
			ctrl2_q <= CSM_CTRL2_RST;
			trim_q  <= CSM_TRIM_RST;
			fine_period_trim_q <= 1'b0;
		end else if (wr_fire && wstrb0_q) begin
			case (awaddr_q)
				CSM_OFS_CTRL1:  ctrl1_q <= wdata_q[7:0];
				CSM_OFS_CTRL2:  ctrl2_q <= wdata_q[7:0];
				CSM_OFS_TRIM:   trim_q  <= wdata_q[7:0];
				CSM_OFS_STATUS: fine_period_trim_q <= wdata_q[0]; // other status bits ignore writes
				default:        fine_period_trim_q <= fine_period_trim_q;
			endcase
		end
	end

	// read channel: one read at a time, data one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= CSM_RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= CSM_RESP_OKAY;
			case (s_axi_araddr)
				CSM_OFS_CTRL1:  s_axi_rdata <= {24'h0, ctrl1_q};
				CSM_OFS_CTRL2:  s_axi_rdata <= {24'h0, ctrl2_q};
				CSM_OFS_TRIM:   s_axi_rdata <= {24'h0, trim_q};
				CSM_OFS_STATUS: s_axi_rdata <= {24'h0, status};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= CSM_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule // csm_clock_select
`default_nettype wire

// ---- test/csm_clock_select_asserts.sv ----
// checker: bus handshake and clock path properties of the clock source selector
`timescale 1ns/1ns
`default_nettype none
module csm_clock_select_asserts
	import csm_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        stop_req,
	input wire logic        int_ref_tick,
	input wire logic        ext_ref_tick,
	input wire logic        fll_enable,
	input wire logic        fll_ref_is_int,
	input wire logic        int_ref_enable,
	input wire logic        ext_ref_enable,
	input wire logic        fll_ref_tick,
	input wire logic        internal_ref_clock_out,
	input wire logic        out_clock_tick,
	input wire logic        bus_clock_tick,
	input wire logic        debug_clock_tick
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// every property ties an output to its cause with the figure from the hand-over timing
	property p_reset_fei; $rose(aresetn) |-> fll_enable && fll_ref_is_int && int_ref_enable && !ext_ref_enable; endproperty
	a_reset_fei: assert property (p_reset_fei) else $error("reset state is not fll engaged internal");
	property p_stop_quiet; stop_req [*4] |-> !fll_enable && !out_clock_tick && !debug_clock_tick; endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("clock activity during stop");
	property p_dbg_off; !fll_enable [*4] |-> !debug_clock_tick; endproperty
	a_dbg_off: assert property (p_dbg_off) else $error("debug clock with fll off");
	property p_irc_gate; internal_ref_clock_out |-> $past(int_ref_tick) || $past(int_ref_tick, 2); endproperty
	a_irc_gate: assert property (p_irc_gate) else $error("internal ref out without a ref tick");
	property p_bus_half; bus_clock_tick |-> $past(out_clock_tick) ##1 !bus_clock_tick; endproperty
	a_bus_half: assert property (p_bus_half) else $error("bus tick not half of output");
	property p_fref_src; fll_ref_tick |-> $past(int_ref_tick, 2) || $past(ext_ref_tick, 2); endproperty
	a_fref_src: assert property (p_fref_src) else $error("fll reference tick without source tick");
	property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_wresp: assert property (p_wresp) else $error("write response late");
	property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rresp: assert property (p_rresp) else $error("read data late");
	property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_w_block: assert property (p_w_block) else $error("write accepted while response pending");
	property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_r_block: assert property (p_r_block) else $error("read accepted while data pending");

	// main scenarios: stop, low-power bypass, register read
	c_stop: cover property (stop_req [*4]);
	c_lp_bypass: cover property (!fll_enable && out_clock_tick);
	c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule // csm_clock_select_asserts

bind csm_clock_select csm_clock_select_asserts u_chk (.*);
`default_nettype wire

// ---- test/csm_chip_side.sv ----
// partner model: reference oscillators, fll output and oscillator start-up seen from the chip side
`timescale 1ns/1ns
`default_nettype none
module csm_chip_side
	import csm_pkg::*;
#(
	parameter int INT_P    = 4,
	parameter int EXT_P    = 6,
	parameter int DCO_P    = 2,
	parameter int OSC_WAIT = 16
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic fll_enable,
	input  wire logic int_ref_enable,
	input  wire logic ext_ref_enable,
	input  wire logic ext_osc_request,
	output var  logic int_ref_tick,
	output var  logic ext_ref_tick,
	output var  logic dco_tick,
	output var  logic osc_init_done
);
	int ci, ce, cd, co;

	// each source pulses once a period and stands still while disabled, so a stray enable shows up
	always_ff @(posedge aclk) begin
		ci <= (!aresetn || !int_ref_enable || ci == INT_P - 1) ? 0 : ci + 1;
		ce <= (!aresetn || !ext_ref_enable || ce == EXT_P - 1) ? 0 : ce + 1;
		cd <= (!aresetn || !fll_enable || cd == DCO_P - 1) ? 0 : cd + 1;
		int_ref_tick <= aresetn && int_ref_enable && ci == INT_P - 1;
		ext_ref_tick <= aresetn && ext_ref_enable && ce == EXT_P - 1;
		dco_tick <= aresetn && fll_enable && cd == DCO_P - 1;
	end

	// oscillator start-up: ready after a fixed count of requested cycles
	always_ff @(posedge aclk) begin
		co <= (!aresetn || !ext_osc_request) ? 0 : (co < OSC_WAIT ? co + 1 : co);
		osc_init_done <= co == OSC_WAIT;
	end
endmodule // csm_chip_side
`default_nettype wire

// ---- test/csm_clock_select_tb.sv ----
// testbench: registers, mode table, dividers and stop behaviour of the clock source selector
`timescale 1ns/1ns
`default_nettype none
module csm_clock_select_tb import csm_pkg::*;;
	logic        aclk = 1'b0, aresetn = 1'b0, stop_req = 1'b0, background_debug = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        int_ref_tick, ext_ref_tick, dco_tick, osc_init_done, fll_enable, fll_ref_is_int, fll_ref_tick;
	logic        int_ref_enable, ext_ref_enable, ext_range_high, ext_high_gain, ext_osc_request, fine_trim;
	logic        internal_ref_clock_out, ext_ref_clock_out, out_clock_tick, bus_clock_tick, debug_clock_tick;
	logic [7:0]  ref_trim;
	logic [31:0] d;
	logic [1:0]  r;
	int          n_fail = 0, checked = 0;
	logic [31:0] c_out, c_bus, c_dbg, c_irc, c_ref, c_erc;
	typedef struct { logic [7:0] c1, c2; logic bd; int o, dg; logic [7:0] st; } csm_row_t;
	// ctrl1, ctrl2, debug session, output and debug ticks per 240 cycles, status
	csm_row_t tbl[10] = '{'{8'h00, 8'h00, 1'b0, 120, 60, 8'h00}, '{8'h44, 8'h00, 1'b0, 60, 60, 8'h14},
		'{8'h44, 8'h08, 1'b0, 60, 0, 8'h14}, '{8'h44, 8'h08, 1'b1, 60, 60, 8'h14},
		'{8'h80, 8'h00, 1'b0, 40, 60, 8'h08}, '{8'h80, 8'h08, 1'b0, 40, 0, 8'h08},
		'{8'hC4, 8'h00, 1'b0, 120, 60, 8'h10}, '{8'h04, 8'h80, 1'b0, 30, 60, 8'h10},
		'{8'h04, 8'hC0, 1'b0, 15, 60, 8'h10}, '{8'h04, 8'h08, 1'b0, 120, 60, 8'h10}};
	logic [7:0]  sc[4] = '{8'h04, 8'h05, 8'h81, 8'h83};
	logic        se[4] = '{1'b0, 1'b1, 1'b0, 1'b1};

	always #10 aclk = ~aclk;
	csm_clock_select dut (.*);
	csm_chip_side u_side (.*);

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// tick counts within two of the target count as the target: windows cut pulses at both ends
	// counts are four-state, so a pulse output that goes unknown leaves an unknown count behind
	function automatic logic [31:0] nr(input logic [31:0] seen, input logic [31:0] exp);
		return (seen >= exp - 2 && seen <= exp + 2) ? exp : seen;
	endfunction
	task automatic summarize;
		if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tmo;
		check("handshake wait", 32'h0, 32'h1);
		summarize;
	endtask
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [7:0] v, output logic [1:0] rs);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (i == 40) tmo;
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == 40) tmo;
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wrc(input logic [3:0] a, input logic [7:0] v);
		logic [1:0] rs;
		wr(a, v, rs);
		check("write resp", rs, CSM_RESP_OKAY);
	endtask
	task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rs;
		rd(a, v, rs);
		check(nm, v, e);
		check("read resp", rs, CSM_RESP_OKAY);
	endtask
	// settle after a change, then count each pulse output over a window
	task automatic measure(input int n);
		c_out = 0; c_bus = 0; c_dbg = 0; c_irc = 0; c_ref = 0; c_erc = 0;
		repeat (40) @(posedge aclk);
		repeat (n) begin
			@(posedge aclk);
			c_out += out_clock_tick;
			c_bus += bus_clock_tick;
			c_dbg += debug_clock_tick;
			c_irc += internal_ref_clock_out;
			c_ref += fll_ref_tick;
			c_erc += ext_ref_clock_out;
		end
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc("ctrl1", CSM_OFS_CTRL1, 32'h04);
		rc("ctrl2", CSM_OFS_CTRL2, 32'h40);
		rc("trim", CSM_OFS_TRIM, 32'h80);
		rc("status", CSM_OFS_STATUS, 32'h10);
		measure(240);
		check("fei out", nr(c_out, 60), 60);
		check("fei debug", nr(c_dbg, 60), 60);
		// only the fine trim bit of status takes a write
		wrc(CSM_OFS_STATUS, 8'hFF);
		rc("status", CSM_OFS_STATUS, 32'h11);
		check("fine trim out", fine_trim, 1'b1);
		wrc(CSM_OFS_STATUS, 8'h00);
		wrc(CSM_OFS_TRIM, 8'h3C);
		rc("trim", CSM_OFS_TRIM, 32'h3C);
		check("trim out", ref_trim, 8'h3C);
		wr(4'h2, 8'h55, r);
		check("unmapped write", r, CSM_RESP_SLVERR);
		rd(4'h2, d, r);
		check("unmapped read", d, 32'h0);
		check("unmapped resp", r, CSM_RESP_SLVERR);
		foreach (tbl[k]) begin
			wrc(CSM_OFS_CTRL2, tbl[k].c2);
			wrc(CSM_OFS_CTRL1, tbl[k].c1);
			background_debug <= tbl[k].bd;
			measure(240);
			check("out ticks", nr(c_out, tbl[k].o), tbl[k].o);
			check("bus ticks", nr(c_bus, tbl[k].o / 2), tbl[k].o / 2);
			check("debug ticks", nr(c_dbg, tbl[k].dg), tbl[k].dg);
			check("fll on", fll_enable, tbl[k].dg != 0);
			rc("status", CSM_OFS_STATUS, tbl[k].st);
		end
		background_debug <= 1'b0;
		wrc(CSM_OFS_CTRL2, 8'h00);
		// divider sweep upward, so the old count never lies past the new terminal count
		for (int n = 0; n < 8; n++) begin
			wrc(CSM_OFS_CTRL1, {2'b00, n[2:0], 3'b100});
			repeat (300) @(posedge aclk);
			measure(1024);
			check("ref ticks", nr(c_ref, 256 >> n), 256 >> n);
		end
		wrc(CSM_OFS_CTRL1, 8'h00);
		measure(1024);
		check("ext ref ticks", nr(c_ref, 170), 170);
		check("ref is int", fll_ref_is_int, 1'b0);
		// external side: oscillator control copies, gated reference out, oscillator ready set and cleared
		wrc(CSM_OFS_CTRL2, 8'h37);
		measure(240);
		check("ext range", ext_range_high, 1'b1);
		check("ext gain", ext_high_gain, 1'b1);
		check("osc request", ext_osc_request, 1'b1);
		check("ext ref on", ext_ref_enable, 1'b1);
		check("erc on", nr(c_erc, 40), 40);
		rc("status", CSM_OFS_STATUS, 32'h02);
		wrc(CSM_OFS_CTRL2, 8'h00);
		rc("status", CSM_OFS_STATUS, 32'h00);
		wrc(CSM_OFS_CTRL1, 8'h06);
		measure(240);
		check("irc on", nr(c_irc, 60), 60);
		wrc(CSM_OFS_CTRL1, 8'h04);
		measure(240);
		check("irc off", c_irc, 0);
		foreach (sc[k]) begin
			wrc(CSM_OFS_CTRL1, sc[k]);
			stop_req <= 1'b1;
			measure(100);
			check("stop out", c_out + c_dbg, 0);
			check("stop fll", fll_enable, 1'b0);
			check("stop int ref", int_ref_enable, se[k]);
			stop_req <= 1'b0;
		end
		summarize;
	end
endmodule // csm_clock_select_tb
`default_nettype wire
